// ==== smcf_consts.svh ====
// constants for the second smbus port configuration block
// assumes inclusion by bare name from the package and design files
`ifndef SMCF_CONSTS_SVH
`define SMCF_CONSTS_SVH
`define SMCF_CFG_ADDR       8'hc1
`define SMCF_CFG_RESET      8'h00
`define SMCF_BIT_PORT_ON    7
`define SMCF_BIT_SLV_MASK   6
`define SMCF_BIT_XFER       5
`define SMCF_BIT_EXTEND     4
`define SMCF_BIT_LOW_TO     3
`define SMCF_BIT_FREE_TO    2
`define SMCF_SRC_HI         1
`define SMCF_SRC_LO         0
`define SMCF_FREE_PERIODS   4'ha
`define SMCF_SRC_T0         2'h0
`define SMCF_SRC_T5         2'h1
`define SMCF_SRC_T2H        2'h2
`define SMCF_SRC_T2L        2'h3
`endif

// ==== smcf_pkg.sv ====
// types for the smbus port configuration block
// assumes smcf_consts.svh is on the include path
`include "smcf_consts.svh"
package smcf_pkg;
  typedef enum logic [1:0] {SMCF_SRC_TMR0, SMCF_SRC_TMR5, SMCF_SRC_TMR2H, SMCF_SRC_TMR2L} smcf_src_t;
  typedef enum {SMCF_IDLE, SMCF_BUSY} smcf_state_t;
endpackage : smcf_pkg

// ==== smcf_pin_if.sv ====
// carrier for the synchronised wire levels between the top and the line watcher
// assumes one clock domain, mclk
interface smcf_pin_if;
  logic sda;   // synchronised data wire
  logic scl;   // synchronised clock wire
  logic start; // start seen, one-cycle pulse
  logic stop;  // stop seen, one-cycle pulse
  modport watcher (output sda, output scl, output start, output stop);
  modport user (input sda, input scl, input start, input stop);
endinterface : smcf_pin_if

// ==== smcf_line_watch.sv ====
// line watcher: synchronises both wires and flags start and stop
// assumes asynchronous wires; three flops, change counted when stages two and three agree
module smcf_line_watch
  import smcf_pkg::*;
(
  input  wire logic   mclk,     // system clock
  input  wire logic   resetn,   // async reset, active low
  input  wire logic   clk_en,   // freezes state while low
  input  wire logic   sda_in,   // raw data wire
  input  wire logic   scl_in,   // raw clock wire
  smcf_pin_if.watcher pins      // filtered levels and events
);
  logic [2:0] sda_sync;
  logic [2:0] scl_sync;
  logic       sda_q;
  logic       scl_q;
  wire        sda_agree = (sda_sync[1] == sda_sync[2]);
  wire        scl_agree = (scl_sync[1] == scl_sync[2]);
  wire        next_sda  = sda_agree ? sda_sync[2] : sda_q;
  wire        next_scl  = scl_agree ? scl_sync[2] : scl_q;
  // idle bus is high; reset to high so no false event appears at release
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sda_sync <= 3'h7;
      scl_sync <= 3'h7;
      sda_q    <= 1'b1;
      scl_q    <= 1'b1;
    end
    else if (clk_en)
    begin
      sda_sync <= {sda_sync[1:0], sda_in};
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_q    <= next_sda;
      scl_q    <= next_scl;
    end
  end
  assign pins.sda   = sda_q;
  assign pins.scl   = scl_q;
  assign pins.start = clk_en && sda_q && !next_sda && scl_q && next_scl;
  assign pins.stop  = clk_en && !sda_q && next_sda && scl_q && next_scl;
endmodule : smcf_line_watch

// ==== smcf_port_cfg.sv ====
// configuration and busy tracking for the second smbus port
// assumes a byte-wide special-function register port and an outside byte engine
// What this block does
// R1: setting bit 7 switches the port on and it watches both wires while the bit stays set.
// R2: while bit 6 is 1, slave-side events raise no interrupt.
// R3: master-mode interrupts pass whatever bit 6 holds.
// R4: hardware sets the read-only busy flag in bit 5 while a transfer runs; writes cannot change it.
// R5: the busy flag clears on a stop or on free-timeout expiry.
// R6: with free timeout on, both wires high for more than 10 source periods frees the bus.
// R7: bit 4 selects normal (0) or extended (1) data setup and hold timing.
// R8: bits 1:0 select timer 0, timer 5, timer 2 high or timer 2 low overflow as bit-rate source.
// R9: writable bits read back what was written and all bits reset to zero.
`include "smcf_consts.svh"
module smcf_port_cfg
  import smcf_pkg::*;
#(
  parameter int FREE_PERIODS = 10 // source periods of idle before bus is free
)
(
  input  wire logic       mclk,          // system clock, 100 MHz
  input  wire logic       resetn,        // async reset, active low
  input  wire logic       clk_en,        // freezes all state while low
  input  wire logic [7:0] sfr_addr,      // register address
  input  wire logic [7:0] sfr_wdata,     // write data
  input  wire logic       sfr_wr,        // write strobe
  input  wire logic       sfr_rd,        // read strobe
  output logic      [7:0] sfr_rdata,     // read data, registered
  input  wire logic       port1_data_wire,  // data wire level
  input  wire logic       port1_clock_wire, // clock wire level
  input  wire logic       tmr0_ovf,      // timer 0 overflow pulse
  input  wire logic       tmr5_ovf,      // timer 5 overflow pulse
  input  wire logic       tmr2h_ovf,     // timer 2 high byte overflow pulse
  input  wire logic       tmr2l_ovf,     // timer 2 low byte overflow pulse
  input  wire logic       slave_evt,     // slave-side event from byte engine
  input  wire logic       master_evt,    // master-side event from byte engine
  output logic            irq,           // interrupt request pulse
  output logic            port_on,       // interface enabled
  output logic            xfer_active,   // bus busy flag
  output logic            sda_timing_extend, // extended setup and hold
  output logic            low_timeout_on,    // scl low timeout enable
  output logic            bitrate_tick,  // selected source overflow, one cycle
  output logic            start_seen,    // start observed on bus
  output logic            stop_seen      // stop observed on bus
);
  // the idle counter is eight bits wide and must see at least one period
  if (FREE_PERIODS < 1 || FREE_PERIODS > 255)
  begin : g_bad_periods
    $error("FREE_PERIODS out of range");
  end

  logic [7:0] port1_cfg_reg;
  logic [7:0] free_cnt;
  smcf_state_t state;
  smcf_pin_if  pins ();

  smcf_line_watch u_watch (
    .mclk   (mclk),
    .resetn (resetn),
    .clk_en (clk_en),
    .sda_in (port1_data_wire),
    .scl_in (port1_clock_wire),
    .pins   (pins)
  );

  wire        cfg_sel         = (sfr_addr == `SMCF_CFG_ADDR);
  wire        cfg_wr          = clk_en && sfr_wr && cfg_sel;
  wire        en              = port1_cfg_reg[`SMCF_BIT_PORT_ON];
  wire        slave_irq_mask  = port1_cfg_reg[`SMCF_BIT_SLV_MASK];
  wire        free_timeout_on = port1_cfg_reg[`SMCF_BIT_FREE_TO];
  wire [1:0]  bitrate_src_sel = port1_cfg_reg[`SMCF_SRC_HI:`SMCF_SRC_LO];
  wire        busy            = (state == SMCF_BUSY);
  // source mux: the four overflow pulses share one tick
  wire        src_tick        = (bitrate_src_sel == `SMCF_SRC_T0)  ? tmr0_ovf  : // R8
                                (bitrate_src_sel == `SMCF_SRC_T5)  ? tmr5_ovf  : // R8
                                (bitrate_src_sel == `SMCF_SRC_T2H) ? tmr2h_ovf : tmr2l_ovf; // R8
  wire        both_high       = pins.sda && pins.scl;
  wire        free_expire     = en && free_timeout_on && both_high && src_tick &&
                                (free_cnt == 8'(FREE_PERIODS)); // R6
  wire        ev_start        = en && pins.start; // R1
  wire        ev_stop         = en && pins.stop;  // R1
  wire        next_irq        = en && ((slave_evt && !slave_irq_mask) || master_evt); // R2 R3
  wire [7:0]  rd_view         = {port1_cfg_reg[7:6], busy, port1_cfg_reg[4:0]}; // R4 R9
  wire [7:0]  next_rdata      = (sfr_rd && cfg_sel) ? rd_view : 8'h00;

  // config bits: busy position is never stored from software
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      port1_cfg_reg <= `SMCF_CFG_RESET; // R9
    else if (cfg_wr)
      port1_cfg_reg <= sfr_wdata & ~(8'h01 << `SMCF_BIT_XFER); // R4 R9
  end

  // idle counter counts source periods while both wires stay high; one past the limit frees
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      free_cnt <= 8'h00;
    else if (clk_en)
    begin
      if (!both_high || !en)
        free_cnt <= 8'h00;
      else if (src_tick && free_cnt != 8'hff)
        free_cnt <= free_cnt + 8'h01; // R6
    end
  end

  // a start in the same cycle as a stop or timeout keeps the bus busy
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      state <= SMCF_IDLE;
    else if (clk_en)
    begin
      unique case (state)
        SMCF_IDLE:
          if (ev_start)
            state <= SMCF_BUSY; // R4
        SMCF_BUSY:
          if (!en || ((ev_stop || free_expire) && !ev_start))
            state <= SMCF_IDLE; // R5
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sfr_rdata         <= 8'h00;
      irq               <= 1'b0;
      port_on           <= 1'b0;
      xfer_active       <= 1'b0;
      sda_timing_extend <= 1'b0;
      low_timeout_on    <= 1'b0;
      bitrate_tick      <= 1'b0;
      start_seen        <= 1'b0;
      stop_seen         <= 1'b0;
    end
    else if (clk_en)
    begin
      sfr_rdata         <= next_rdata;
      irq               <= next_irq; // R2 R3
      port_on           <= en; // R1
      xfer_active       <= busy; // R4
      sda_timing_extend <= port1_cfg_reg[`SMCF_BIT_EXTEND]; // R7
      low_timeout_on    <= port1_cfg_reg[`SMCF_BIT_LOW_TO];
      bitrate_tick      <= en && src_tick; // R8
      start_seen        <= ev_start;
      stop_seen         <= ev_stop;
    end
  end

  slave_inhibit_a: assert property (@(posedge mclk) disable iff (!resetn) // R2
    (clk_en && slave_irq_mask && !master_evt) |=> !irq)
    else $error("slave event raised an interrupt while inhibited");
  master_pass_a: assert property (@(posedge mclk) disable iff (!resetn) // R3
    (clk_en && en && master_evt) |=> irq)
    else $error("master event lost");
  busy_set_a: assert property (@(posedge mclk) disable iff (!resetn) // R4
    (clk_en && ev_start) |=> busy)
    else $error("start did not set busy");
  busy_clear_a: assert property (@(posedge mclk) disable iff (!resetn) // R5
    (clk_en && busy && en && ev_stop && !ev_start) |=> !busy)
    else $error("stop did not clear busy");
  busy_ro_a: assert property (@(posedge mclk) disable iff (!resetn) // R4
    cfg_wr |=> (busy == $past(busy) || $past(ev_start || ev_stop || free_expire || !en)))
    else $error("write changed busy");
  free_limit_a: assert property (@(posedge mclk) disable iff (!resetn) // R6
    (clk_en && en && busy && both_high && src_tick && free_cnt < 8'(FREE_PERIODS)) |=> busy)
    else $error("free timeout too early");
  readback_a: assert property (@(posedge mclk) disable iff (!resetn) // R9
    cfg_wr |=> (port1_cfg_reg == ($past(sfr_wdata) & 8'hdf)))
    else $error("config did not hold written value");
  extend_out_a: assert property (@(posedge mclk) disable iff (!resetn) // R7
    clk_en |=> (sda_timing_extend == $past(port1_cfg_reg[`SMCF_BIT_EXTEND])))
    else $error("timing extend not following bit");
  port_on_a: assert property (@(posedge mclk) disable iff (!resetn) // R1
    (clk_en && !en) |=> (!port_on && !start_seen && !stop_seen))
    else $error("start seen while port off");
  port_follow_a: assert property (@(posedge mclk) disable iff (!resetn) // R1
    clk_en |=> (port_on == $past(en)))
    else $error("enable output not following bit");
  off_idle_a: assert property (@(posedge mclk) disable iff (!resetn) // R1
    (clk_en && !en) |=> !busy)
    else $error("busy held while port off");
  irq_off_a: assert property (@(posedge mclk) disable iff (!resetn) // R1
    (clk_en && !en) |=> !irq)
    else $error("interrupt while port off");
  slave_pass_a: assert property (@(posedge mclk) disable iff (!resetn) // R2
    (clk_en && en && slave_evt && !slave_irq_mask) |=> irq)
    else $error("slave event lost while not inhibited");
  busy_bit_a: assert property (@(posedge mclk) disable iff (!resetn) // R4
    !port1_cfg_reg[`SMCF_BIT_XFER])
    else $error("busy position stored from software");
  xfer_out_a: assert property (@(posedge mclk) disable iff (!resetn) // R4
    clk_en |=> (xfer_active == $past(busy)))
    else $error("busy output not following state");
  busy_view_a: assert property (@(posedge mclk) disable iff (!resetn) // R4
    (clk_en && sfr_rd && cfg_sel) |=> (sfr_rdata[`SMCF_BIT_XFER] == $past(busy)))
    else $error("read does not show busy");
  timeout_clear_a: assert property (@(posedge mclk) disable iff (!resetn) // R5
    (clk_en && busy && free_expire && !ev_start) |=> !busy)
    else $error("free timeout did not clear busy");
  free_count_a: assert property (@(posedge mclk) disable iff (!resetn) // R6
    (clk_en && en && both_high && src_tick && free_cnt != 8'hff) |=> (free_cnt == $past(free_cnt) + 8'h01))
    else $error("idle counter missed a source period");
  free_restart_a: assert property (@(posedge mclk) disable iff (!resetn) // R6
    (clk_en && !both_high) |=> (free_cnt == 8'h00))
    else $error("idle counter kept counting with a wire low");
  // with the timeout off only a stop or disabling the port may free the bus
  free_off_a: assert property (@(posedge mclk) disable iff (!resetn) // R6
    (clk_en && en && busy && !free_timeout_on && !ev_stop) |=> busy)
    else $error("bus freed with free timeout off");
  tick_t5_a: assert property (@(posedge mclk) disable iff (!resetn) // R8
    (clk_en && en && bitrate_src_sel == `SMCF_SRC_T5) |=> (bitrate_tick == $past(tmr5_ovf)))
    else $error("timer 5 tick not routed");
  tick_t2h_a: assert property (@(posedge mclk) disable iff (!resetn) // R8
    (clk_en && en && bitrate_src_sel == `SMCF_SRC_T2H) |=> (bitrate_tick == $past(tmr2h_ovf)))
    else $error("timer 2 high tick not routed");
  tick_off_a: assert property (@(posedge mclk) disable iff (!resetn) // R8
    (clk_en && !en) |=> !bitrate_tick)
    else $error("tick while port off");
  read_idle_a: assert property (@(posedge mclk) disable iff (!resetn) // R9
    (clk_en && !(sfr_rd && cfg_sel)) |=> (sfr_rdata == 8'h00))
    else $error("read data without a read");
  // a low enable must hold the config bits, idle counter, bus state and a pending interrupt
  freeze_a: assert property (@(posedge mclk) disable iff (!resetn)
    (!clk_en) |=> ($stable(port1_cfg_reg) && $stable(free_cnt) && $stable(state) && $stable(irq)))
    else $error("state moved while clock enable low");
endmodule : smcf_port_cfg

// ==== smcf_bus_peer.sv ====
// far-side bus device: drives the data and clock wires, open drain with pull-up
// assumes nothing else pulls the wires low
module smcf_bus_peer;
  timeunit 1ns;
  timeprecision 100ps;
  logic sda = 1'b1; // data wire level
  logic scl = 1'b1; // clock wire level
  // both wires released idle high, as the pull-ups leave them
  task automatic hold(input int n);
    repeat (n) #10;
  endtask : hold
  task automatic send_start;
    sda = 1'b0;
    hold(8);
  endtask : send_start
  task automatic send_stop;
    scl = 1'b0;
    hold(4);
    sda = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(4);
    sda = 1'b1;
    hold(8);
  endtask : send_stop
  // raise data while the clock is low so no stop is signalled
  task automatic go_quiet;
    scl = 1'b0;
    hold(4);
    sda = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(8);
  endtask : go_quiet
endmodule : smcf_bus_peer

// ==== tb_smbus_second_port_config.sv ====
// self-checking bench for the port configuration block
// assumes the peer model drives the bus wires; free timeout at its default of 10 periods
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_smbus_second_port_config;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FP = 10;
  logic mclk = 0, resetn = 0, wr = 0, rd = 0, sev = 0, mev = 0, ce = 1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [3:0] tmr = 4'h0;
  logic irq, on, busy, ext, lto, tick, st, sp;
  int fail_count = 0, comparisons = 0, exp_cfg = 0, exp_busy = 0, starts = 0, stops = 0;
  logic [31:0] seed = 32'd35;
  smcf_bus_peer u_smcf_bus_peer();
  smcf_port_cfg #(.FREE_PERIODS(FP)) u_smcf_port_cfg (.mclk(mclk), .resetn(resetn), .clk_en(ce),
    .sfr_addr(addr), .sfr_wdata(wdata), .sfr_wr(wr), .sfr_rd(rd), .sfr_rdata(rdata),
    .port1_data_wire(u_smcf_bus_peer.sda), .port1_clock_wire(u_smcf_bus_peer.scl),
    .tmr0_ovf(tmr[0]), .tmr5_ovf(tmr[1]), .tmr2h_ovf(tmr[2]), .tmr2l_ovf(tmr[3]),
    .slave_evt(sev), .master_evt(mev), .irq(irq), .port_on(on), .xfer_active(busy),
    .sda_timing_extend(ext), .low_timeout_on(lto), .bitrate_tick(tick),
    .start_seen(st), .stop_seen(sp));
  initial forever #5 mclk = ~mclk;
  // one-cycle event pulses are tallied so scenarios can check them later
  always @(posedge mclk)
  begin
    starts += int'(st);
    stops += int'(sp);
  end
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xorshift
  task automatic step(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1;
    step();
    wr = 0;
    if (a == 8'hc1) exp_cfg = d & 8'hdf;
  endtask : wr_reg
  // read data lands on the edge that takes the strobe
  task automatic rd_chk(input logic [7:0] a);
    addr = a;
    rd = 1;
    step();
    rd = 0;
    `CHK(rdata, (a == 8'hc1) ? 8'(exp_cfg | (exp_busy << 5)) : 8'h00)
  endtask : rd_chk
  task automatic pulse(ref logic s, input logic exp_irq);
    s = 1;
    step();
    s = 0;
    `CHK(irq, exp_irq)
  endtask : pulse
  task automatic wait_busy(input logic v);
    for (int i = 0; i < 20 && busy !== v; i++) step();
    exp_busy = v;
  endtask : wait_busy
  task automatic complete_run;
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  initial
  begin
    #200us;
    fail_count++;
    complete_run();
  end
  initial
  begin
    step(16);
    resetn = 1;
    rd_chk(8'hc1);
    for (int i = 0; i < 6; i++)
    begin
      seed = xorshift(seed);
      wr_reg(8'hc1, seed[7:0]);
      step();
      `CHK({on, ext, lto}, {seed[7], seed[4], seed[3]})
      rd_chk(8'hc1);
      step();
      rd_chk(seed[15:8] | 8'h01);
    end
    for (int s = 0; s < 4; s++)
    begin
      wr_reg(8'hc1, 8'h80 | 8'(s));
      for (int k = 0; k < 4; k++)
      begin
        tmr[k] = 1;
        step();
        tmr[k] = 0;
        `CHK(tick, 1'(k == s))
      end
    end
    wr_reg(8'hc1, 8'hc0);
    pulse(sev, 1'b0);
    ce = 0;
    pulse(mev, 1'b0);
    ce = 1;
    step();
    pulse(mev, 1'b1);
    wr_reg(8'hc1, 8'h80);
    pulse(sev, 1'b1);
    u_smcf_bus_peer.send_start();
    wait_busy(1'b1);
    `CHK(busy, 1'b1)
    `CHK(starts, 1)
    wr_reg(8'hc1, 8'h80);
    rd_chk(8'hc1);
    u_smcf_bus_peer.send_stop();
    wait_busy(1'b0);
    `CHK(busy, 1'b0)
    `CHK(stops, 1)
    wr_reg(8'hc1, 8'h84);
    u_smcf_bus_peer.send_start();
    wait_busy(1'b1);
    u_smcf_bus_peer.go_quiet();
    repeat (FP)
    begin
      tmr[0] = 1;
      step();
      tmr[0] = 0;
      step(2);
    end
    `CHK(busy, 1'b1)
    tmr[0] = 1;
    step();
    tmr[0] = 0;
    step(3);
    `CHK(busy, 1'b0)
    exp_busy = 0;
    rd_chk(8'hc1);
    `CHK(starts, 2)
    `CHK(stops, 1)
    complete_run();
  end
endmodule : tb_smbus_second_port_config
